// file: design/smrs_top.sv
/*
 * smrs_top: stop-mode recovery selector with Avalon-MM register slave.
 * Assumes one 20 MHz clock, power-on reset on i_rst_n, a separate
 * stop-recovery reset request, and port lines synchronous to the clock.
 */
// Behaviour
// - first source field picks reset-only, port-three lines 1-3 or port-two line 7 singly, or port-two NORs.
// - second field 001/010 give NAND of port-two lines 0-3 or 0-7.
// - second field 011/100 give NOR/NAND of port-three lines 1-3.
// - second field 101/110 add port-zero lines 0 and 7 to those.
// - second field 111 adds port-two lines 0-2; 000 means reset-only.
// - either qualified wake event ends stop mode.
// - first level bit picks active polarity, reset default low.
// - second level bit picks polarity of the second source.
// - stop flag reads 0 after power-on, 1 after stop recovery.
// - power-on-only fields survive stop-mode recovery.
// - first register bits 6-0 write-only, bit 7 read-only flag.
// - second source field keeps its value through stop recovery.
`timescale 1ns/1ps
module smrs_top #(
	parameter int SETTLE_CYCLES = smrs_pkg::SETTLE_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// stop-mode recovery reset from the core
	input wire logic i_stop_reset,
	// Avalon-MM slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// port lines
	input wire logic [7:0] i_port_zero,
	input wire logic [7:0] i_port_two,
	input wire logic [7:0] i_port_three,
	// core clock control
	output logic o_clk_run,
	output logic o_hold_exec,
	output logic o_stopped
);
	logic [2:0] src1;
	logic level1;
	logic delay_on;
	logic stop_flag;
	logic [2:0] src2;
	logic level2;
	logic wake;
	logic ack;
	logic req;
	logic wr_low;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic stop_cmd;
	logic [11:0] settle_cnt;
	smrs_pkg::smrs_state_e state;
	smrs_pkg::smrs_state_e next_state;

	assign req = (i_avs_read | i_avs_write) & ~ack;
	assign idx = i_avs_address;
	assign wdat = i_avs_writedata[7:0];
	// writes land at the edge where the master sees waitrequest low
	assign wr_low = i_avs_write & ack & i_avs_byteenable[0];

	// one wait cycle: ack rises the cycle after a request appears
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~req;
		end
	end

	// power-on-only fields: stop reset does not touch them
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			src1 <= smrs_pkg::SRC_RESET;
			level1 <= smrs_pkg::LEVEL_RESET;
			delay_on <= smrs_pkg::DELAY_RESET;
			src2 <= smrs_pkg::SRC_RESET;
			level2 <= smrs_pkg::LEVEL_RESET;
		end else if (wr_low) begin
			if (idx == smrs_pkg::IDX_CTRL) begin
				// bit 7 ignored on write
				src1 <= wdat[smrs_pkg::CTRL_SRC_LSB +: 3];
				delay_on <= wdat[smrs_pkg::CTRL_DELAY_BIT];
				level1 <= wdat[smrs_pkg::CTRL_LEVEL_BIT];
			end
			if (idx == smrs_pkg::IDX_CTRL2) begin
				src2 <= wdat[smrs_pkg::CTRL2_SRC_LSB +: 3];
				level2 <= wdat[smrs_pkg::CTRL2_LEVEL_BIT];
			end
		end
	end

	// stop flag: set on recovery, cleared only by power-on
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stop_flag <= 1'b0;
		end else if (i_stop_reset || (state == smrs_pkg::SMRS_STOP && wake)) begin
			stop_flag <= 1'b1;
		end
	end

	assign stop_cmd = wr_low && idx == smrs_pkg::IDX_CMD
		&& wdat[smrs_pkg::CMD_STOP_BIT];

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_readdata <= 32'h0;
		end else if (i_avs_read && req) begin
			case (idx)
				// write-only bits read zero
				smrs_pkg::IDX_CTRL:
					o_avs_readdata <= {24'h0, stop_flag, 7'h0};
				smrs_pkg::IDX_STATUS:
					o_avs_readdata <= {29'h0, o_hold_exec, o_stopped, wake};
				default: o_avs_readdata <= 32'h0;
			endcase
		end
	end

	smrs_wake_sel u_wake (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_src1(src1),
		.i_level1(level1),
		.i_src2(src2),
		.i_level2(level2),
		.i_port_zero(i_port_zero),
		.i_port_two(i_port_two),
		.i_port_three(i_port_three),
		.o_wake(wake)
	);

	always_comb begin
		next_state = state;
		case (state)
			smrs_pkg::SMRS_RUN:
				if (stop_cmd) next_state = smrs_pkg::SMRS_STOP;
			smrs_pkg::SMRS_STOP:
				if (wake) begin
					next_state = delay_on ? smrs_pkg::SMRS_SETTLE
						: smrs_pkg::SMRS_RUN;
				end
			smrs_pkg::SMRS_SETTLE:
				if (settle_cnt == 12'h0) next_state = smrs_pkg::SMRS_RUN;
			default: next_state = smrs_pkg::SMRS_RUN;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= smrs_pkg::SMRS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// counter reloads on every cycle in stop, then counts down to zero in any state
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_cnt <= 12'h0;
		end else if (state == smrs_pkg::SMRS_STOP) begin
			settle_cnt <= 12'(SETTLE_CYCLES - 1);
		end else if (settle_cnt != 12'h0) begin
			settle_cnt <= settle_cnt - 12'h1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_clk_run <= 1'b1;
			o_hold_exec <= 1'b0;
			o_stopped <= 1'b0;
		end else begin
			o_clk_run <= next_state != smrs_pkg::SMRS_STOP;
			o_hold_exec <= next_state != smrs_pkg::SMRS_RUN;
			o_stopped <= next_state == smrs_pkg::SMRS_STOP;
		end
	end
endmodule : smrs_top

// file: design/smrs_wake_sel.sv
/*
 * smrs_wake_sel: decodes both recovery-source selections against the
 * port lines and applies each polarity bit; registered wake output.
 * Assumes port lines are synchronous to the system clock.
 */
`timescale 1ns/1ps
module smrs_wake_sel (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// selections
	input wire logic [2:0] i_src1,
	input wire logic i_level1,
	input wire logic [2:0] i_src2,
	input wire logic i_level2,
	// port lines
	input wire logic [7:0] i_port_zero,
	input wire logic [7:0] i_port_two,
	input wire logic [7:0] i_port_three,
	// qualified wake
	output logic o_wake
);
	logic raw1;
	logic raw2;
	logic en1;
	logic en2;
	logic [2:0] p3;
	logic [4:0] p3p0;
	logic [5:0] p3p2;

	assign p3 = i_port_three[3:1];
	assign p3p0 = {p3, i_port_zero[0], i_port_zero[7]};
	assign p3p2 = {p3, i_port_two[2:0]};

	always_comb begin
		en1 = 1'b1;
		case (i_src1)
			3'h2: raw1 = i_port_three[1];
			3'h3: raw1 = i_port_three[2];
			3'h4: raw1 = i_port_three[3];
			3'h5: raw1 = i_port_two[7];
			3'h6: raw1 = ~|i_port_two[3:0];
			3'h7: raw1 = ~|i_port_two;
			default: begin
				// 000 reset only, 001 reserved: no pin wake
				raw1 = 1'b0;
				en1 = 1'b0;
			end
		endcase
	end

	always_comb begin
		en2 = 1'b1;
		case (i_src2)
			3'h1: raw2 = ~&i_port_two[3:0];
			3'h2: raw2 = ~&i_port_two;
			3'h3: raw2 = ~|p3;
			3'h4: raw2 = ~&p3;
			3'h5: raw2 = ~|p3p0;
			3'h6: raw2 = ~&p3p0;
			3'h7: raw2 = ~&p3p2;
			default: begin
				raw2 = 1'b0;
				en2 = 1'b0;
			end
		endcase
	end

	// level 0 means a low signal is the event, hence the inversion
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= (en1 & (raw1 ^ ~i_level1))
				| (en2 & (raw2 ^ ~i_level2));
		end
	end
endmodule : smrs_wake_sel

// file: dv/smrs_pins.sv
/*
 * smrs_pins: the outside wake sources, port lines set by the bench.
 * Assumes the lines change only with the system clock.
 */
`timescale 1ns/1ps
module smrs_pins (
	// clock and requested levels
	input wire logic i_clk_sys,
	input wire logic [23:0] i_level,
	// port lines
	output logic [7:0] o_port_zero,
	output logic [7:0] o_port_two,
	output logic [7:0] o_port_three
);
	// registered so that pins move only on the device's sampling edge
	always_ff @(posedge i_clk_sys) begin
		{o_port_zero, o_port_two, o_port_three} <= i_level;
	end
endmodule : smrs_pins

// file: dv/smrs_top_props.sv
/*
 * smrs_top_props: port checks of the stop-mode recovery selector.
 * Assumes it is bound onto smrs_top and sees only its ports.
 */
`timescale 1ns/1ps
module smrs_top_chk #(
	parameter int SETTLE_CYCLES = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_stop_reset,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [7:0] i_port_zero,
	input wire logic [7:0] i_port_two,
	input wire logic [7:0] i_port_three,
	input wire logic o_clk_run,
	input wire logic o_hold_exec,
	input wire logic o_stopped
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic seen_flag;
	int settle_cnt;
	wire logic rd_ack = i_avs_read && !o_avs_waitrequest;
	wire logic rd_ctrl = rd_ack && i_avs_address == 8'h0B;
	// once a control read showed the flag set, only power-on may clear the flag
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			seen_flag <= 1'b0;
		else if (rd_ctrl && o_avs_readdata[7])
			seen_flag <= 1'b1;
	end
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			settle_cnt <= 0;
		else
			settle_cnt <= (o_hold_exec && !o_stopped) ? settle_cnt + 1 : 0;
	end
	property p_stop_halt;
		o_stopped |-> !o_clk_run && o_hold_exec;
	endproperty
	a_stop_halt: assert property (p_stop_halt)
		else $error("clock runs in stop");
	property p_resume;
		$fell(o_stopped) |-> o_clk_run;
	endproperty
	a_resume: assert property (p_resume)
		else $error("clock not restarted");
	property p_settle_max;
		settle_cnt <= SETTLE_CYCLES;
	endproperty
	a_settle_max: assert property (p_settle_max)
		else $error("settling too long");
	property p_ctrl_read;
		rd_ctrl |-> o_avs_readdata[6:0] == 7'h00;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("write-only bits read back");
	property p_ctrl2_read;
		rd_ack && i_avs_address == 8'h0D |-> o_avs_readdata == 32'h0;
	endproperty
	a_ctrl2_read: assert property (p_ctrl2_read)
		else $error("second register read back");
	property p_flag_sticky;
		rd_ctrl && seen_flag |-> o_avs_readdata[7];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("stop flag lost");
	property p_wait_one;
		!o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low too long");
	property p_answer;
		$rose(i_avs_read || i_avs_write) |-> ##[1:3] !o_avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no bus answer");
	c_wake: cover property ($fell(o_stopped));
	c_settle: cover property (o_hold_exec && !o_stopped);
	c_flag: cover property (rd_ctrl && o_avs_readdata[7]);
endmodule : smrs_top_chk
bind smrs_top smrs_top_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);

// file: dv/smrs_top_test.sv
/*
 * smrs_top_test: register and wake-source checks of smrs_top.
 * Assumes smrs_pins drives the ports and a short settle count.
 */
`timescale 1ns/1ps
module smrs_top_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [23:0] pins = 24'hFFFFFF;
	logic srst = 1'b0;
	logic [31:0] rdata;
	logic wrq, run, hold, stp;
	logic [7:0] p0, p2, p3;
	int n_errors = 0;
	int n_compared = 0;
	always #25 clk = ~clk;
	smrs_top #(.SETTLE_CYCLES(8)) uut (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_stop_reset(srst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wrq),
		.i_port_zero(p0), .i_port_two(p2), .i_port_three(p3),
		.o_clk_run(run), .o_hold_exec(hold), .o_stopped(stp));
	smrs_pins u_pins (.i_clk_sys(clk), .i_level(pins), .o_port_zero(p0),
		.o_port_two(p2), .o_port_three(p3));
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// values read just after an edge are those the edge sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge clk);
		adr <= a;
		wd <= {24'h0, d};
		rd <= !w;
		wr <= w;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wrq !== 1'b0 && k < 20);
		if (k >= 20) begin
			n_errors++;
			conclude;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic wake(input logic [7:0] c1, input logic [7:0] c2,
		input logic [23:0] idle, input logic [23:0] act);
		logic [31:0] q;
		int k;
		pins <= idle;
		bus(1'b1, 8'h0B, c1, q);
		bus(1'b1, 8'h0D, c2, q);
		bus(1'b1, 8'h11, 8'h01, q);
		repeat (4) @(negedge clk);
		check("stopped", 1, stp);
		@(posedge clk);
		pins <= act;
		k = 0;
		while (stp !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		check("woken", 0, stp);
		k = 0;
		while (hold === 1'b1 && k < 40) begin
			@(negedge clk);
			k++;
		end
		check("settle", c1[5] ? 8 : 0, k);
		check("run", 1, run);
		bus(1'b0, 8'h0B, 8'h00, q);
		check("flag", 1, q[7]);
		$display("wake case %h %h done", c1, c2);
	endtask : wake
	// power-on reset mid-run, then a stop reset must keep source two
	task automatic recover;
		logic [31:0] q;
		int k;
		pins <= 24'hFF00FF;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h0B, 8'h00, q);
		check("flag after reset", 0, q[7]);
		bus(1'b1, 8'h0D, 8'h04, q);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		bus(1'b0, 8'h0B, 8'h00, q);
		check("flag after stop reset", 1, q[7]);
		bus(1'b1, 8'h11, 8'h01, q);
		repeat (4) @(negedge clk);
		check("stopped again", 1, stp);
		@(posedge clk);
		pins <= 24'hFF0FFF;
		k = 0;
		while (stp !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		check("source kept", 0, stp);
		$display("recovery case done");
	endtask : recover
	initial begin
		logic [31:0] q;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h0B, 8'h00, q);
		check("flag at power-on", 0, q[7]);
		bus(1'b0, 8'h20, 8'h00, q);
		check("unmapped", 0, q);
		$display("reset case done");
		wake(8'h08, 8'h00, 24'hFFFFFF, 24'hFFFFFD);
		wake(8'h5C, 8'h00, 24'hFFFFFF, 24'hFF00FF);
		wake(8'h00, 8'h04, 24'hFF00FF, 24'hFF0FFF);
		wake(8'h00, 8'h54, 24'hFFFFFF, 24'h7EFFF1);
		wake(8'h10, 8'h04, 24'hFF00FF, 24'hFF00F7);
		recover;
		wake(8'h28, 8'h00, 24'hFFFFFF, 24'hFFFFFD);
		wake(8'h00, 8'h0C, 24'hFFFFF1, 24'hFFFFF3);
		wake(8'h00, 8'h1C, 24'hFFF8FF, 24'hFFFFFF);
		wake(8'h18, 8'h00, 24'hFFF0FF, 24'hFFF1FF);
		wake(8'h14, 8'h00, 24'hFFFFFF, 24'hFF7FFF);
		conclude;
	end
endmodule : smrs_top_test

// file: include/smrs_pkg.sv
/*
 * smrs_pkg: register offsets, field positions, reset values and timing
 * constants for the stop-mode recovery selector.
 * Assumes byte-wide registers placed on 32-bit Avalon-MM words.
 */
package smrs_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h0B;
	localparam logic [7:0] IDX_CTRL2 = 8'h0D;
	localparam logic [7:0] IDX_STATUS = 8'h10;
	localparam logic [7:0] IDX_CMD = 8'h11;
	localparam int ADDR_W = 8;

	// first control register fields
	localparam int CTRL_SRC_LSB = 2;
	localparam int CTRL_DELAY_BIT = 5;
	localparam int CTRL_LEVEL_BIT = 6;
	localparam int CTRL_FLAG_BIT = 7;
	// second control register fields
	localparam int CTRL2_SRC_LSB = 2;
	localparam int CTRL2_LEVEL_BIT = 6;

	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic LEVEL_RESET = 1'b0;
	localparam logic DELAY_RESET = 1'b1;

	// command register bits
	localparam int CMD_STOP_BIT = 0;

	// oscillator settling time
	localparam int SETTLE_US = 100;
	localparam int CLK_MHZ = 20;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int SETTLE_W = 12;

	typedef enum logic [1:0] {
		SMRS_RUN = 2'b00,
		SMRS_STOP = 2'b01,
		SMRS_SETTLE = 2'b10
	} smrs_state_e;
endpackage : smrs_pkg
